// ===== mixext_bank.sv
// Extended mixer register bank: index and data ports, extended access control,
// extended control registers, legacy line remapping and mixer control outputs.
// Assumes host strobes are synchronous one-cycle pulses and that mode, wavetable
// enable and configuration load inputs come from elsewhere in the codec.
module mixext_bank #(
	parameter logic [7:0] VERSION_ID = 8'h5a // Arbitrary identification value
) (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic [1:0] bus_addr_in,
	input wire logic bus_wr_in,
	input wire logic bus_rd_in,
	input wire logic [7:0] bus_wdata_in,
	output logic [7:0] bus_rdata_out,
	input wire logic mode3_in,
	input wire logic wavetable_port_enable_in,
	input wire logic cfg_load_in,
	input wire logic cfg_synth_enable_in,
	output logic [4:0] left_line_gain_out,
	output logic [4:0] right_line_gain_out,
	output logic [1:0] line_bypass_mute_out,
	output logic [1:0] line_alt_in_mute_out,
	output logic [1:0] line_alt_out_mute_out,
	output logic [4:0] left_mic_gain_out,
	output logic [4:0] right_mic_gain_out,
	output logic [1:0] mic_boost_out,
	output logic [1:0] mic_out_mute_out,
	output logic [1:0] mic_in_mute_out,
	output logic [1:0] left_input_sum_atten_out,
	output logic [1:0] right_input_sum_atten_out,
	output logic mono_in_right_mute_out,
	output logic mono_out_right_mute_out,
	output logic internal_synth_enable_out,
	output logic master_from_ext_out,
	output logic [5:0] left_synth_atten_out,
	output logic [5:0] right_synth_atten_out,
	output logic [1:0] synth_mute_out,
	output logic [5:0] left_serial_port_atten_out,
	output logic left_serial_port_mute_out
);

	// Index register state
	logic [4:0] index_r; // Selected indirect index
	logic mce_r; // Mode change enable bit
	logic trd_r; // Transfer request disable bit

	// Extended access control state
	logic [4:0] ext_index_field_r; // Selected extended register
	logic ext_index_enable_r; // Data port points at extended data
	logic acf_r; // Stored autocalibrate bit

	// Register storage
	logic [7:0] xreg_r [0:mixext_pkg::X_FLOP_COUNT-1]; // Extended words held in flops
	logic [7:0] wave_r [0:1]; // Left and right wavetable volume
	logic [7:0] legacy_left_line_reg_r; // Legacy left line register
	logic [7:0] legacy_right_line_reg_r; // Legacy right line register
	logic ifse_r; // Copy of independent rate enable

	// Read path
	logic [7:0] rd_flop_r; // Read data from flops
	logic [7:0] rd_flop_nxt; // Next read data from flops
	logic rd_use_mem_r; // Last read was served by memory
	logic rd_use_mem_nxt; // Current read is served by memory
	logic [7:0] mem_rdata; // Memory read data
	logic [2:0] mem_addr; // Memory word address

	// Decoded strobes
	logic data_wr; // Write to the data port
	logic ext_wr; // Write to an extended register
	logic ext_role; // Data port is in extended data role
	logic leg_wr_l; // Write to legacy left line register
	logic leg_wr_r; // Write to legacy right line register
	logic mem_wr; // Write to a memory-held word
	logic [7:0] ext_wdata; // Masked extended write data

	// Remap controls
	logic synth_on; // Internal synth enabled
	logic synth_remap; // Legacy writes go to synth volume
	logic wave_remap; // Legacy writes go to wavetable volume
	logic remap_active; // Line volume comes from alternate registers

	// Combinational decode of host accesses
	always_comb begin
		data_wr = bus_wr_in && bus_addr_in == mixext_pkg::OFS_DATA;
		ext_role = ext_index_enable_r && mode3_in && index_r == mixext_pkg::IDX_EXT_CTRL;
		ext_wr = data_wr && ext_role;
		leg_wr_l = data_wr && index_r == mixext_pkg::IDX_LEGACY_LEFT;
		leg_wr_r = data_wr && index_r == mixext_pkg::IDX_LEGACY_RIGHT;
		ext_wdata = bus_wdata_in & mixext_pkg::mixext_xmask(ext_index_field_r);
		mem_addr = 3'(ext_index_field_r - mixext_pkg::X_LOOPBACK);
		mem_wr = ext_wr && ext_index_field_r >= mixext_pkg::X_LOOPBACK
			&& ext_index_field_r <= mixext_pkg::X_MASTER_R
			&& (ifse_r || (ext_index_field_r != mixext_pkg::X_ADC_RATE
			&& ext_index_field_r != mixext_pkg::X_DAC_RATE));
	end

	// Remap conditions from the synth and mixer control word
	always_comb begin
		synth_on = xreg_r[4][mixext_pkg::F_SYNTH_ENABLE_BIT];
		synth_remap = synth_on && xreg_r[4][mixext_pkg::F_SYNTH_REMAP_BIT];
		wave_remap = wavetable_port_enable_in && !xreg_r[4][mixext_pkg::F_WAVE_NOREMAP_BIT];
		remap_active = synth_remap || wave_remap;
	end

	// Index register; any write here ends the extended data role
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			index_r <= mixext_pkg::IDXR_RESET[4:0];
			mce_r <= mixext_pkg::IDXR_RESET[mixext_pkg::IDXR_MODE_CHG_BIT];
			trd_r <= 1'b0;
		end else if (bus_wr_in && bus_addr_in == mixext_pkg::OFS_INDEX) begin
			index_r <= bus_wdata_in[4:0];
			mce_r <= bus_wdata_in[mixext_pkg::IDXR_MODE_CHG_BIT];
			trd_r <= bus_wdata_in[mixext_pkg::IDXR_XFER_DIS_BIT];
		end
	end

	// Extended access control: index field and enable
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ext_index_field_r <= 5'h00;
			ext_index_enable_r <= 1'b0;
			acf_r <= 1'b0;
		end else if (!mode3_in) begin
			ext_index_enable_r <= 1'b0;
		end else if (bus_wr_in && bus_addr_in == mixext_pkg::OFS_INDEX) begin
			ext_index_enable_r <= 1'b0;
		end else if (data_wr && index_r == mixext_pkg::IDX_EXT_CTRL && !ext_index_enable_r) begin
			ext_index_field_r <= {bus_wdata_in[mixext_pkg::XC_IDX_TOP_BIT], bus_wdata_in[7:4]};
			ext_index_enable_r <= bus_wdata_in[mixext_pkg::XC_EXT_ENABLE_BIT];
			acf_r <= bus_wdata_in[mixext_pkg::XC_ACF_BIT];
		end
	end

	// Flop-held extended words with legacy redirection into synth volume
	always_ff @(posedge clk_sys_in) begin
		for (int i = 0; i < mixext_pkg::X_FLOP_COUNT; i++) begin
			if (rst_in) begin
				xreg_r[i] <= mixext_pkg::mixext_xreset(5'(i));
			end else if (ext_wr && ext_index_field_r == 5'(i)) begin
				xreg_r[i] <= ext_wdata;
			end else if (i == 6 && leg_wr_l && synth_remap) begin
				// Same masked value as a direct write, so it reads back identically
				xreg_r[i] <= bus_wdata_in & mixext_pkg::mixext_xmask(mixext_pkg::X_SYNTH_L);
			end else if (i == 7 && leg_wr_r && synth_remap) begin
				xreg_r[i] <= bus_wdata_in & mixext_pkg::mixext_xmask(mixext_pkg::X_SYNTH_R);
			end
		end
		// Configuration load overrides a host write in the same cycle
		if (!rst_in && cfg_load_in) begin
			xreg_r[4][mixext_pkg::F_SYNTH_ENABLE_BIT] <= cfg_synth_enable_in;
		end
	end

	// Wavetable volume words with legacy redirection
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			wave_r[0] <= mixext_pkg::mixext_xreset(mixext_pkg::X_WAVE_L);
			wave_r[1] <= mixext_pkg::mixext_xreset(mixext_pkg::X_WAVE_R);
		end else begin
			if (ext_wr && ext_index_field_r == mixext_pkg::X_WAVE_L) begin
				wave_r[0] <= ext_wdata;
			end else if (leg_wr_l && wave_remap) begin
				wave_r[0] <= bus_wdata_in & mixext_pkg::mixext_xmask(mixext_pkg::X_WAVE_L);
			end
			if (ext_wr && ext_index_field_r == mixext_pkg::X_WAVE_R) begin
				wave_r[1] <= ext_wdata;
			end else if (leg_wr_r && wave_remap) begin
				wave_r[1] <= bus_wdata_in & mixext_pkg::mixext_xmask(mixext_pkg::X_WAVE_R);
			end
		end
	end

	// Legacy line registers always keep what the host wrote
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			legacy_left_line_reg_r <= mixext_pkg::RST_LEGACY;
			legacy_right_line_reg_r <= mixext_pkg::RST_LEGACY;
		end else begin
			if (leg_wr_l) begin
				legacy_left_line_reg_r <= bus_wdata_in;
			end
			if (leg_wr_r) begin
				legacy_right_line_reg_r <= bus_wdata_in;
			end
		end
	end

	// Copy of the rate enable bit, gates writes to the rate words
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			ifse_r <= mixext_pkg::RST_DAC_MUTE[mixext_pkg::F_IFSE_BIT];
		end else if (ext_wr && ext_index_field_r == mixext_pkg::X_DAC_MUTE) begin
			ifse_r <= bus_wdata_in[mixext_pkg::F_IFSE_BIT];
		end
	end

	// Memory for the words that only software reads back
	mixext_xmem u_xmem (
		.clk_sys_in(clk_sys_in),
		.rst_in(rst_in),
		.wr_en_in(mem_wr),
		.wr_addr_in(mem_addr),
		.wr_data_in(ext_wdata),
		.rd_en_in(bus_rd_in && rd_use_mem_nxt),
		.rd_addr_in(mem_addr),
		.rd_data_out(mem_rdata)
	);

	// Read data selection for words held in flops
	always_comb begin
		rd_flop_nxt = 8'h00;
		rd_use_mem_nxt = 1'b0;
		case (bus_addr_in)
			mixext_pkg::OFS_INDEX: begin
				rd_flop_nxt = {1'b0, mce_r, trd_r, index_r};
			end
			mixext_pkg::OFS_DATA: begin
				if (ext_role) begin
					if (ext_index_field_r < 5'(mixext_pkg::X_FLOP_COUNT)) begin
						rd_flop_nxt = xreg_r[ext_index_field_r[3:0]];
					end else if (ext_index_field_r <= mixext_pkg::X_MASTER_R) begin
						rd_use_mem_nxt = 1'b1;
					end else if (ext_index_field_r == mixext_pkg::X_WAVE_L) begin
						rd_flop_nxt = wave_r[0];
					end else if (ext_index_field_r == mixext_pkg::X_WAVE_R) begin
						rd_flop_nxt = wave_r[1];
					end else if (ext_index_field_r == mixext_pkg::X_VERSION) begin
						rd_flop_nxt = VERSION_ID;
					end
				end else if (index_r == mixext_pkg::IDX_EXT_CTRL) begin
					rd_flop_nxt = {ext_index_field_r[3:0], ext_index_enable_r,
						ext_index_field_r[4], 1'b0, acf_r};
				end else if (index_r == mixext_pkg::IDX_LEGACY_LEFT) begin
					rd_flop_nxt = legacy_left_line_reg_r;
				end else if (index_r == mixext_pkg::IDX_LEGACY_RIGHT) begin
					rd_flop_nxt = legacy_right_line_reg_r;
				end
			end
			default: begin
				rd_flop_nxt = 8'h00;
			end
		endcase
	end

	// Read data register, updated on each read strobe
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rd_flop_r <= 8'h00;
			rd_use_mem_r <= 1'b0;
		end else if (bus_rd_in) begin
			rd_flop_r <= rd_flop_nxt;
			rd_use_mem_r <= rd_use_mem_nxt;
		end
	end

	// Both sources are registers; the select is registered too
	assign bus_rdata_out = rd_use_mem_r ? mem_rdata : rd_flop_r;

	// Line path controls; gain follows alternate registers while remapped
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			left_line_gain_out <= mixext_pkg::RST_LEGACY[4:0];
			right_line_gain_out <= mixext_pkg::RST_LEGACY[4:0];
			// Alternate line words reset with all three mutes set
			line_bypass_mute_out <= 2'h3;
			line_alt_in_mute_out <= 2'h3;
			line_alt_out_mute_out <= 2'h3;
		end else begin
			left_line_gain_out <= remap_active ? xreg_r[0][4:0] : legacy_left_line_reg_r[4:0];
			right_line_gain_out <= remap_active ? xreg_r[1][4:0] : legacy_right_line_reg_r[4:0];
			line_bypass_mute_out <= {xreg_r[1][mixext_pkg::F_BYPASS_BIT],
				xreg_r[0][mixext_pkg::F_BYPASS_BIT]};
			line_alt_in_mute_out <= {xreg_r[1][mixext_pkg::F_IN_MUTE_BIT],
				xreg_r[0][mixext_pkg::F_IN_MUTE_BIT]};
			line_alt_out_mute_out <= {xreg_r[1][mixext_pkg::F_OUT_MUTE_BIT],
				xreg_r[0][mixext_pkg::F_OUT_MUTE_BIT]};
		end
	end

	// Microphone and input mixer controls
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			left_mic_gain_out <= mixext_pkg::RST_MIC[4:0];
			right_mic_gain_out <= mixext_pkg::RST_MIC[4:0];
			mic_boost_out <= 2'h0;
			mic_out_mute_out <= 2'h3;
			mic_in_mute_out <= 2'h3;
			left_input_sum_atten_out <= 2'h0;
			right_input_sum_atten_out <= 2'h0;
			mono_in_right_mute_out <= 1'b1;
			mono_out_right_mute_out <= 1'b0;
		end else begin
			left_mic_gain_out <= xreg_r[2][4:0];
			right_mic_gain_out <= xreg_r[3][4:0];
			mic_boost_out <= {xreg_r[3][mixext_pkg::F_BYPASS_BIT],
				xreg_r[2][mixext_pkg::F_BYPASS_BIT]};
			mic_out_mute_out <= {xreg_r[3][mixext_pkg::F_IN_MUTE_BIT],
				xreg_r[2][mixext_pkg::F_IN_MUTE_BIT]};
			mic_in_mute_out <= {xreg_r[3][mixext_pkg::F_OUT_MUTE_BIT],
				xreg_r[2][mixext_pkg::F_OUT_MUTE_BIT]};
			left_input_sum_atten_out <= xreg_r[4][mixext_pkg::F_SUM_LSB +: 2];
			right_input_sum_atten_out <= xreg_r[5][mixext_pkg::F_SUM_LSB +: 2];
			mono_in_right_mute_out <= xreg_r[4][mixext_pkg::F_MONO_BIT];
			mono_out_right_mute_out <= xreg_r[5][mixext_pkg::F_MONO_BIT];
		end
	end

	// Synth, master role and serial port controls
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			internal_synth_enable_out <= 1'b0;
			master_from_ext_out <= 1'b0;
			left_synth_atten_out <= 6'h00;
			right_synth_atten_out <= 6'h00;
			synth_mute_out <= 2'h3;
			left_serial_port_atten_out <= 6'h00;
			left_serial_port_mute_out <= 1'b0;
		end else begin
			internal_synth_enable_out <= synth_on;
			master_from_ext_out <= synth_on || wavetable_port_enable_in;
			left_synth_atten_out <= xreg_r[6][5:0];
			right_synth_atten_out <= xreg_r[7][5:0];
			synth_mute_out <= {xreg_r[7][mixext_pkg::F_MUTE_BIT],
				xreg_r[6][mixext_pkg::F_MUTE_BIT]};
			left_serial_port_atten_out <= xreg_r[8][5:0];
			left_serial_port_mute_out <= xreg_r[8][mixext_pkg::F_MUTE_BIT];
		end
	end

	// Checks next to the logic above
	a_index_clears_enable: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		bus_wr_in && bus_addr_in == mixext_pkg::OFS_INDEX |=> !ext_index_enable_r)
		else $error("extended enable survived an index write");
	a_mode3_only: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		!mode3_in |=> !ext_index_enable_r)
		else $error("extended enable set outside third mode");
	a_synth_redirect: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		leg_wr_l && synth_remap && !cfg_load_in |=> xreg_r[6] == ($past(bus_wdata_in) & 8'hbf))
		else $error("legacy write not redirected to synth volume");
	a_synth_no_remap: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		leg_wr_l && !synth_remap |=> $stable(xreg_r[6]))
		else $error("synth volume changed without remap");
	a_wave_redirect: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		leg_wr_r && wave_remap |=> wave_r[1] == ($past(bus_wdata_in) & 8'hbf))
		else $error("legacy write not redirected to wavetable volume");
	a_wave_no_remap: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		leg_wr_l && !wave_remap |=> $stable(wave_r[0]))
		else $error("wavetable volume changed while remap disabled");
	a_both_redirect: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		leg_wr_l && synth_remap && wave_remap |=> xreg_r[6] == wave_r[0])
		else $error("dual redirect did not update both targets");
	a_line_gain_sel: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		remap_active ##1 remap_active |-> left_line_gain_out == $past(xreg_r[0][4:0]))
		else $error("line gain not taken from alternate register");
	a_cfg_synth_load: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		cfg_load_in && cfg_synth_enable_in |=> ##1 internal_synth_enable_out && master_from_ext_out)
		else $error("configuration load did not enable synth");
	a_readback_match: assert property (@(posedge clk_sys_in) disable iff (rst_in)
		bus_rd_in && ext_role && ext_index_field_r == mixext_pkg::X_SYNTH_L
		|=> bus_rdata_out == $past(xreg_r[6]))
		else $error("synth volume read back differs from stored value");

endmodule

// ===== mixext_pkg.sv
// Constants for the extended mixer register bank: offsets, indices, field
// positions, reset values and write masks.
// Assumes one system clock and a synchronous reset in the user modules.
package mixext_pkg;

	// Direct register offsets on the host port
	localparam logic [1:0] OFS_INDEX = 2'h0; // Index address register
	localparam logic [1:0] OFS_DATA = 2'h1; // Indexed data port

	// Indirect indices handled by this bank
	localparam logic [4:0] IDX_LEGACY_LEFT = 5'h12; // Legacy left line register
	localparam logic [4:0] IDX_LEGACY_RIGHT = 5'h13; // Legacy right line register
	localparam logic [4:0] IDX_EXT_CTRL = 5'h17; // Extended access control

	// Extended register indices
	localparam logic [4:0] X_LINE_L = 5'h00; // Left line alternate volume
	localparam logic [4:0] X_LINE_R = 5'h01; // Right line alternate volume
	localparam logic [4:0] X_MIC_L = 5'h02; // Left mic volume
	localparam logic [4:0] X_MIC_R = 5'h03; // Right mic volume
	localparam logic [4:0] X_SYNTH_MIX = 5'h04; // Synth and input mixer control
	localparam logic [4:0] X_RIGHT_MIX = 5'h05; // Right input mixer control
	localparam logic [4:0] X_SYNTH_L = 5'h06; // Left synth volume
	localparam logic [4:0] X_SYNTH_R = 5'h07; // Right synth volume
	localparam logic [4:0] X_DSP_L = 5'h08; // Left serial port volume
	localparam logic [4:0] X_LOOPBACK = 5'h0a; // First word held in memory
	localparam logic [4:0] X_DAC_MUTE = 5'h0b; // DAC mute and rate select
	localparam logic [4:0] X_ADC_RATE = 5'h0c; // ADC sample rate
	localparam logic [4:0] X_DAC_RATE = 5'h0d; // DAC sample rate
	localparam logic [4:0] X_MASTER_R = 5'h0f; // Last word held in memory
	localparam logic [4:0] X_WAVE_L = 5'h10; // Left wavetable volume
	localparam logic [4:0] X_WAVE_R = 5'h11; // Right wavetable volume
	localparam logic [4:0] X_VERSION = 5'h19; // Chip version and id
	localparam int X_FLOP_COUNT = 10; // First ten extended words kept in flops
	localparam int X_MEM_DEPTH = 6; // Next six extended words kept in memory

	// Index register fields
	localparam int IDXR_MODE_CHG_BIT = 6; // Mode change enable
	localparam int IDXR_XFER_DIS_BIT = 5; // Transfer request disable
	localparam logic [7:0] IDXR_RESET = 8'h40; // Index register after reset

	// Extended access control fields
	localparam int XC_EXT_ENABLE_BIT = 3; // Extended index enable
	localparam int XC_IDX_TOP_BIT = 2; // Top bit of extended index
	localparam int XC_ACF_BIT = 0; // Autocalibrate flag bit

	// Field positions inside extended registers
	localparam int F_OUT_MUTE_BIT = 7; // Line out mute / mic in mute
	localparam int F_IN_MUTE_BIT = 6; // Line in mute / mic out mute
	localparam int F_BYPASS_BIT = 5; // Line bypass mute / mic boost
	localparam int F_MONO_BIT = 7; // Mono mutes in both mixer control words
	localparam int F_SUM_LSB = 5; // Summing attenuator low bit
	localparam int F_SYNTH_ENABLE_BIT = 4; // Internal synth enable
	localparam int F_WAVE_NOREMAP_BIT = 3; // Wavetable remap disable
	localparam int F_SYNTH_REMAP_BIT = 2; // Synth volume remap
	localparam int F_MUTE_BIT = 7; // Synth and serial port mute
	localparam int F_IFSE_BIT = 5; // Independent rate enable

	// Reset values of extended registers
	localparam logic [7:0] RST_LINE = 8'he8;
	localparam logic [7:0] RST_MIC = 8'hcf;
	localparam logic [7:0] RST_SYNTH_MIX = 8'h84;
	localparam logic [7:0] RST_SYNTH_VOL = 8'h80;
	localparam logic [7:0] RST_LOOPBACK = 8'h3f;
	localparam logic [7:0] RST_DAC_MUTE = 8'hc0;
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_LEGACY = 8'h88; // Legacy line regs after reset

	// Writable bits per extended register; reserved bits store as zero
	function automatic logic [7:0] mixext_xmask(input logic [4:0] idx);
		case (idx)
			5'h00, 5'h01, 5'h02, 5'h03: mixext_xmask = 8'hff;
			5'h04: mixext_xmask = 8'hfc;
			5'h05, 5'h0b: mixext_xmask = 8'he0;
			5'h06, 5'h07, 5'h08, 5'h09, 5'h0a, 5'h10, 5'h11: mixext_xmask = 8'hbf;
			5'h0c, 5'h0d, 5'h0e, 5'h0f: mixext_xmask = 8'hff;
			default: mixext_xmask = 8'h00;
		endcase
	endfunction

	// Reset value per extended register
	function automatic logic [7:0] mixext_xreset(input logic [4:0] idx);
		case (idx)
			5'h00, 5'h01: mixext_xreset = RST_LINE;
			5'h02, 5'h03: mixext_xreset = RST_MIC;
			5'h04: mixext_xreset = RST_SYNTH_MIX;
			5'h06, 5'h07: mixext_xreset = RST_SYNTH_VOL;
			5'h0a: mixext_xreset = RST_LOOPBACK;
			5'h0b: mixext_xreset = RST_DAC_MUTE;
			default: mixext_xreset = RST_ZERO;
		endcase
	endfunction

endpackage

// ===== mixext_xmem.sv
// Small register memory for the extended words that steer no local logic.
// Assumes the caller gives word addresses relative to the first held word.
module mixext_xmem (
	input wire logic clk_sys_in,
	input wire logic rst_in,
	input wire logic wr_en_in,
	input wire logic [2:0] wr_addr_in,
	input wire logic [7:0] wr_data_in,
	input wire logic rd_en_in,
	input wire logic [2:0] rd_addr_in,
	output logic [7:0] rd_data_out
);

	logic [7:0] mem_r [0:mixext_pkg::X_MEM_DEPTH-1]; // Stored words

	// Write port, loads reset values on reset
	always_ff @(posedge clk_sys_in) begin
		for (int i = 0; i < mixext_pkg::X_MEM_DEPTH; i++) begin
			if (rst_in) begin
				mem_r[i] <= mixext_pkg::mixext_xreset(5'(i) + mixext_pkg::X_LOOPBACK);
			end else if (wr_en_in && wr_addr_in == 3'(i)) begin
				mem_r[i] <= wr_data_in;
			end
		end
	end

	// Registered read port, holds its value between reads
	always_ff @(posedge clk_sys_in) begin
		if (rst_in) begin
			rd_data_out <= 8'h00;
		end else if (rd_en_in) begin
			rd_data_out <= (rd_addr_in < 3'(mixext_pkg::X_MEM_DEPTH)) ? mem_r[rd_addr_in] : 8'h00;
		end
	end

endmodule

// ===== mixext_bank_test.sv
// Self-checking bench for the extended mixer register bank.
// Assumes the bank alone, driven through its host port and config inputs.
module mixext_bank_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 0, rst_in = 1, bus_wr_in = 0, bus_rd_in = 0, mode3_in = 1;
	logic wt_en = 0, cfg_load_in = 0, cfg_se = 0; // Config side inputs
	logic [1:0] bus_addr_in = 0;
	logic [7:0] bus_wdata_in = 0, bus_rdata_out, d;
	logic [4:0] lmg, lga, rga, rmg;
	logic [5:0] lsa, lsp, rsa;
	logic [1:0] sm, lbm, lim, lom, mb, mom, mim, lsum, rsum;
	logic ise, mfe, left_serial_port_mute, mir, mor;
	int err_count = 0, total_checks = 0, seed = 32'h7823, cyc = 0, i;
	int xt[9] = '{0, 1, 2, 3, 4, 5, 6, 7, 8}; // Extended words with local fields
	logic [7:0] x4v[5] = '{8'h14, 8'h00, 8'h14, 8'h18, 8'h04}; // Remap cases
	logic [4:0] wv = 5'b00110, s6 = 5'b00101, s16 = 5'b00110;
	mixext_bank uut (.clk_sys_in, .rst_in, .bus_addr_in, .bus_wr_in, .bus_rd_in,
		.bus_wdata_in, .bus_rdata_out, .mode3_in, .wavetable_port_enable_in(wt_en),
		.cfg_load_in, .cfg_synth_enable_in(cfg_se), .left_line_gain_out(lga),
		.right_line_gain_out(rga), .line_bypass_mute_out(lbm), .line_alt_in_mute_out(lim),
		.line_alt_out_mute_out(lom), .left_mic_gain_out(lmg), .right_mic_gain_out(rmg),
		.mic_boost_out(mb), .mic_out_mute_out(mom), .mic_in_mute_out(mim),
		.left_input_sum_atten_out(lsum), .right_input_sum_atten_out(rsum),
		.mono_in_right_mute_out(mir), .mono_out_right_mute_out(mor),
		.internal_synth_enable_out(ise), .master_from_ext_out(mfe),
		.left_synth_atten_out(lsa), .right_synth_atten_out(rsa), .synth_mute_out(sm),
		.left_serial_port_atten_out(lsp), .left_serial_port_mute_out(left_serial_port_mute));
	// Clock and hang guard
	initial forever #12.5 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in) begin
		cyc++;
		if (cyc == 8000) begin
			err_count++;
			summarize();
		end
	end
	// Compare one byte
	task chk(string n, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// Stored value of a random write: reserved bits read as zero
	function automatic logic [7:0] stored(int x, logic [7:0] v);
		if (x < 4) return v;
		if (x == 4) return v & 8'hfc;
		if (x == 5) return v & 8'he0;
		return v & 8'hbf;
	endfunction
	// One host write, held over one taking edge, then one idle edge
	task wr(logic [1:0] a, logic [7:0] v);
		bus_addr_in = a;
		bus_wdata_in = v;
		bus_wr_in = 1;
		@(posedge clk_sys_in) #1 bus_wr_in = 0;
		@(posedge clk_sys_in) #1;
	endtask
	// One host read, data checked a cycle later
	task rd(logic [1:0] a, logic [7:0] e, string n);
		bus_addr_in = a;
		bus_rd_in = 1;
		@(posedge clk_sys_in) #1 bus_rd_in = 0;
		@(posedge clk_sys_in) #1 chk(n, e, bus_rdata_out);
	endtask
	// Select an extended word
	task xs(logic [4:0] x);
		wr(0, 8'h17);
		wr(1, {x[3:0], 1'b1, x[4], 2'b00});
	endtask
	task summarize();
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (12) @(posedge clk_sys_in);
		#1 rst_in = 0;
		xs(0); rd(1, 8'he8, "line reset");
		xs(2); rd(1, 8'hcf, "mic reset");
		xs(6); rd(1, 8'h80, "synth reset");
		chk("mic gain reset", 8'h0f, {3'h0, lmg});
		chk("line mutes reset", 8'h3f, {2'h0, lom, lim, lbm});
		$display("reset test done");
		// Random words: reserved bits store as zero, fields reach outputs
		repeat (40) begin
			i = xt[$unsigned($random(seed)) % 9];
			d = $random(seed);
			xs(i[4:0]);
			wr(1, d);
			rd(1, stored(i, d), "xreg");
			if (i == 0) chk("left line", {d[7:5], 5'h00}, {lom[0], lim[0], lbm[0], 5'h00});
			if (i == 1) chk("right line", {d[7:5], 5'h00}, {lom[1], lim[1], lbm[1], 5'h00});
			if (i == 2) chk("left mic", d, {mim[0], mom[0], mb[0], lmg});
			if (i == 3) chk("right mic", d, {mim[1], mom[1], mb[1], rmg});
			if (i == 4) chk("left mix", {d[7:5], 5'h00}, {mir, lsum, 5'h00});
			if (i == 5) chk("right mix", {d[7:5], 5'h00}, {mor, rsum, 5'h00});
			if (i == 7) chk("right synth", {d[7], 1'b0, d[5:0]}, {sm[1], 1'b0, rsa});
			if (i == 6) chk("synth", {d[7], 1'b0, d[5:0]}, {sm[0], 1'b0, lsa});
			if (i == 8) chk("sport", {d[7], 1'b0, d[5:0]}, {left_serial_port_mute, 1'b0, lsp});
		end
		$display("random test done");
		// Legacy line writes under each on/off pairing of synth remap and wavetable remap
		for (int k = 0; k < 5; k++) begin
			d = $random(seed);
			xs(0); wr(1, 8'h03);
			xs(1); wr(1, 8'h05);
			xs(6); wr(1, 8'h00);
			xs(16); wr(1, 8'h00);
			xs(17); wr(1, 8'h00);
			xs(4); wr(1, x4v[k]);
			wt_en = wv[k];
			wr(0, 8'h12); wr(1, d);
			wr(0, 8'h13); wr(1, ~d);
			xs(6); rd(1, s6[k] ? d & 8'hbf : 8'h00, "synth redirect");
			xs(16); rd(1, s16[k] ? d & 8'hbf : 8'h00, "wave redirect");
			xs(17); rd(1, s16[k] ? ~d & 8'hbf : 8'h00, "right wave redirect");
			chk("line gain", (s6[k] | s16[k]) ? 8'h03 : {3'h0, d[4:0]}, {3'h0, lga});
			chk("right gain", (s6[k] | s16[k]) ? 8'h05 : {3'h0, ~d[4:0]}, {3'h0, rga});
			chk("master", {7'h0, x4v[k][4] | wv[k]}, {7'h0, mfe});
		end
		$display("remap test done");
		// Index write drops extended enable, mode gates extended access
		xs(2); wr(1, 8'h55); wr(0, 8'h17); wr(1, 8'h08); wr(1, 8'h1f);
		xs(2); rd(1, 8'h55, "mic kept");
		xs(0); rd(1, 8'h1f, "line hit");
		mode3_in = 0;
		xs(2); wr(1, 8'h00);
		mode3_in = 1;
		xs(2); rd(1, 8'h55, "mic mode");
		wr(2, 8'hff); rd(2, 8'h00, "unmapped");
		cfg_se = 1; cfg_load_in = 1;
		@(posedge clk_sys_in) #1 cfg_load_in = 0;
		xs(4); rd(1, 8'h14, "cfg load");
		chk("synth enable", 8'h01, {7'h0, ise});
		$display("access test done");
		summarize();
	end
endmodule
